// *** mbrw_client_model.sv ***
`timescale 1ns/1ps
module mbrw_client_model #(
    parameter int GAP_P = 20
) (
    // clock
    input wire logic clk_sys_in,
    // replies from the server
    input wire logic [7:0] tx_byte_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    // queries to the server
    output logic [7:0] rx_byte_out,
    output logic rx_valid_out,
    // pacing of the reply side
    input wire logic slow_in,
    input wire logic hold_in
);
    logic [7:0] got_q[$];
    logic [7:0] sent_q[$];
    int tick = 0;

    initial begin
        rx_byte_out = 8'h00;
        rx_valid_out = 1'b0;
    end

    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
            end
        end
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // fields arrive already high byte first from the caller
    task automatic send(input logic [7:0] b[$], input logic bad_crc);
        logic [15:0] c;
        c = crc16(b) ^ {15'h0000, bad_crc};
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        sent_q = b;
        foreach (b[i]) begin
            @(negedge clk_sys_in);
            rx_byte_out <= b[i];
            rx_valid_out <= 1'b1;
            @(negedge clk_sys_in);
            rx_valid_out <= 1'b0;
            // no stale byte left on the line between strobes
            rx_byte_out <= ~b[i];
        end
        // closing gap, also the wait after a broadcast
        repeat (GAP_P + 2) @(negedge clk_sys_in);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // a slow or stalled transmitter, to fill the reply buffer
    always @(negedge clk_sys_in) begin
        tick++;
        tx_ready_out <= !hold_in && !(slow_in && (tick % 3 != 0));
    end

    always @(posedge clk_sys_in) begin
        if (tx_valid_in === 1'b1 && tx_ready_out) begin
            got_q.push_back(tx_byte_in);
        end
    end
endmodule

// *** mbrw_crc16_byte.sv ***
`timescale 1ns/1ps
module mbrw_crc16_byte import mbrw_pkg::*; (
    // running value and next byte
    input wire logic [15:0] crc_in,
    input wire logic [7:0] data_in,
    // value after the byte
    output logic [15:0] crc_out
);
    always_comb begin
        logic [15:0] c;
        c = crc_in ^ {8'h00, data_in};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        crc_out = c;
    end
endmodule

// *** mbrw_pkg.sv ***
// How it works
// - a read sent to address zero is dropped without any action
// - read start field N selects holding register N plus 40001
// - read reply carries byte count twice the quantity, H02 to HFA
// - reply holds exactly quantity words, ascending, high byte first, then CRC
// - write register field N stores into holding register N plus 40001
// - a write sent to address zero is broadcast and is carried out
// - a unicast write is answered with a copy of the query
// - a broadcast write gets no reply at all
// - frames are bounded by idle gaps of at least 3.5 characters
// - CRC of two bytes, low first; receiver checks it while receiving
// - unknown function answers with function code ORed with H80
// - only own station 1 to 247 is answered; replies echo that address
package mbrw_pkg;

    localparam logic [7:0] FC_READ = 8'h03;
    localparam logic [7:0] FC_WRITE = 8'h06;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    localparam logic [7:0] STATION_MIN = 8'h01;
    localparam logic [7:0] STATION_MAX = 8'hF7;
    localparam logic [15:0] QTY_MAX = 16'h007D;
    localparam logic [16:0] REG_BASE = 17'h09C41;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam logic [15:0] CRC_RESIDUE = 16'h0000;

    // frame lengths in bytes, CRC included, and last header byte index of a reply
    localparam logic [3:0] QUERY_LEN = 4'h8;
    localparam logic [3:0] MIN_LEN = 4'h4;
    localparam logic [3:0] LEN_SAT = 4'hF;
    localparam logic [3:0] BUF_DEPTH = 4'h8;
    localparam logic [2:0] HDR_LAST_ECHO = 3'h5;
    localparam logic [2:0] HDR_LAST_SHORT = 3'h2;

    // idle gap: 3.5 characters of 11 bits at 19200 baud
    localparam int CLK_PERIOD_NS = 100;
    localparam int CHAR_TIME_NS = 572917;
    localparam int GAP_NS = CHAR_TIME_NS * 7 / 2;
    localparam int GAP_CYCLES =
        (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [8:0] {
        ST_IDLE   = 9'h001,
        ST_HEAD   = 9'h002,
        ST_RDADDR = 9'h004,
        ST_RDWAIT = 9'h008,
        ST_RDDATA = 9'h010,
        ST_RDHI   = 9'h020,
        ST_RDLO   = 9'h040,
        ST_CRCL   = 9'h080,
        ST_CRCH   = 9'h100
    } mbrw_state_t;

    typedef struct packed {
        logic en;
        logic [16:0] addr;
        logic [15:0] data;
    } mbrw_wr_t;

    typedef struct packed {
        logic en;
        logic [16:0] addr;
    } mbrw_rd_t;

endpackage

// *** mbrw_server.sv ***
`timescale 1ns/1ps
module mbrw_server import mbrw_pkg::*; #(
    parameter int GAP_CYCLES_P = GAP_CYCLES
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // configuration
    input wire logic [7:0] station_number_setting_in,
    // received bytes from the serial receiver
    input wire logic [7:0] rx_byte_in,
    input wire logic rx_valid_in,
    // bytes to the serial transmitter
    output logic [7:0] tx_byte_out,
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    // holding register access
    output mbrw_rd_t reg_rd_out,
    input wire logic [15:0] reg_rd_data_in,
    output mbrw_wr_t reg_wr_out,
    // status
    output logic crc_err_out
);

    ////////////////////////////////////////////////////////////////////
    // receive side: gap timing, byte capture, running CRC

    localparam logic [15:0] GAP_LAST = 16'(GAP_CYCLES_P - 1);

    logic [7:0] rx_buf [0:7];
    logic [3:0] rx_len_reg;
    logic [15:0] gap_cnt_reg;
    logic [15:0] crc_rx_reg;
    logic [15:0] crc_rx_next;
    logic frame_open_reg;
    logic frame_done_reg;

    wire [3:0] rx_idx = frame_open_reg ? rx_len_reg : 4'h0;
    wire [15:0] crc_rx_seed = frame_open_reg ? crc_rx_reg : CRC_INIT;

    mbrw_crc16_byte u_crc_rx (
        .crc_in(crc_rx_seed),
        .data_in(rx_byte_in),
        .crc_out(crc_rx_next)
    );

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_len_reg <= 4'h0;
            gap_cnt_reg <= 16'h0000;
            crc_rx_reg <= CRC_INIT;
            frame_open_reg <= 1'h0;
            frame_done_reg <= 1'h0;
        end else begin
            frame_done_reg <= 1'h0;
            if (rx_valid_in) begin
                frame_open_reg <= 1'h1;
                gap_cnt_reg <= 16'h0000;
                crc_rx_reg <= crc_rx_next;
                if (!frame_open_reg) begin
                    rx_len_reg <= 4'h1;
                end else if (rx_len_reg != LEN_SAT) begin
                    rx_len_reg <= rx_len_reg + 4'h1;
                end
            end else if (frame_open_reg) begin
                if (gap_cnt_reg == GAP_LAST) begin
                    frame_open_reg <= 1'h0;
                    frame_done_reg <= 1'h1;
                end else begin
                    gap_cnt_reg <= gap_cnt_reg + 16'h0001;
                end
            end
        end
    end

    // only the first bytes matter; longer frames are judged on length
    always_ff @(posedge clk_sys_in) begin
        if (rx_valid_in && rx_idx < BUF_DEPTH) begin
            rx_buf[rx_idx[2:0]] <= rx_byte_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // frame decode

    mbrw_state_t state_reg;
    mbrw_state_t state_next;

    wire [7:0] f_addr = rx_buf[0];
    wire [7:0] f_func = rx_buf[1];
    wire [15:0] f_field = {rx_buf[2], rx_buf[3]};
    wire [15:0] f_val = {rx_buf[4], rx_buf[5]};
    wire [16:0] f_reg_num = {1'h0, f_field} + REG_BASE;

    wire crc_ok = crc_rx_reg == CRC_RESIDUE;
    wire station_ok = station_number_setting_in >= STATION_MIN &&
                      station_number_setting_in <= STATION_MAX;
    wire to_me = station_ok && f_addr == station_number_setting_in;
    wire bcast = f_addr == BCAST_ADDR;
    wire is_read = f_func == FC_READ;
    wire is_write = f_func == FC_WRITE;
    wire known = is_read | is_write;
    wire len_ok = known ? rx_len_reg == QUERY_LEN : rx_len_reg >= MIN_LEN;
    wire qty_ok = f_val != 16'h0000 && f_val <= QTY_MAX;

    // a frame that finishes while a reply is still going out is lost
    wire frame_good = frame_done_reg && crc_ok && len_ok &&
                      state_reg == ST_IDLE;
    wire do_write = frame_good && is_write && (to_me || bcast);
    // broadcast reads fail to_me, so they fall out here
    wire do_reply = frame_good && to_me;
    wire reply_read = do_reply && is_read && qty_ok;
    wire reply_echo = do_reply && is_write;
    wire reply_exc = do_reply && !(reply_read || reply_echo);
    wire [7:0] exc_code = known ? EXC_ILL_VALUE : EXC_ILL_FUNC;

    ////////////////////////////////////////////////////////////////////
    // reply state

    logic [7:0] hdr_reg [0:5];
    logic [2:0] hdr_idx_reg;
    logic [2:0] hdr_last_reg;
    logic is_rd_reply_reg;
    logic [16:0] rd_base_reg;
    logic [6:0] rd_qty_reg;
    logic [6:0] rd_idx_reg;
    logic [15:0] word_reg;
    logic [15:0] crc_tx_reg;
    logic [15:0] crc_tx_next;
    logic buf_ready;
    logic [7:0] tx_byte;

    wire in_head = state_reg == ST_HEAD;
    wire in_crcl = state_reg == ST_CRCL;
    wire sending = in_head || state_reg == ST_RDHI ||
                   state_reg == ST_RDLO || in_crcl ||
                   state_reg == ST_CRCH;
    wire tx_push = sending && buf_ready;
    wire crc_push = tx_push && !in_crcl && state_reg != ST_CRCH;
    wire head_done = in_head && hdr_idx_reg == hdr_last_reg;
    wire [6:0] rd_idx_inc = rd_idx_reg + 7'h01;

    // data first, CRC low byte then high byte
    assign tx_byte = in_head ? hdr_reg[hdr_idx_reg] :
                     state_reg == ST_RDHI ? word_reg[15:8] :
                     state_reg == ST_RDLO ? word_reg[7:0] :
                     in_crcl ? crc_tx_reg[7:0] :
                     crc_tx_reg[15:8];

    mbrw_crc16_byte u_crc_tx (
        .crc_in(crc_tx_reg),
        .data_in(tx_byte),
        .crc_out(crc_tx_next)
    );

    mbrw_skid2 #(
        .WIDTH(8)
    ) u_tx_buf (
        .clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in),
        .in_data_in(tx_byte),
        .in_valid_in(sending),
        .in_ready_out(buf_ready),
        .out_data_out(tx_byte_out),
        .out_valid_out(tx_valid_out),
        .out_ready_in(tx_ready_in)
    );

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (do_reply) begin
                    state_next = ST_HEAD;
                end
            end
            ST_HEAD: begin
                if (tx_push && head_done) begin
                    state_next = is_rd_reply_reg ? ST_RDADDR : ST_CRCL;
                end
            end
            ST_RDADDR: state_next = ST_RDWAIT;
            ST_RDWAIT: state_next = ST_RDDATA;
            ST_RDDATA: state_next = ST_RDHI;
            ST_RDHI: begin
                if (tx_push) begin
                    state_next = ST_RDLO;
                end
            end
            ST_RDLO: begin
                if (tx_push) begin
                    state_next = rd_idx_inc == rd_qty_reg ? ST_CRCL
                                                          : ST_RDADDR;
                end
            end
            ST_CRCL: begin
                if (tx_push) begin
                    state_next = ST_CRCH;
                end
            end
            ST_CRCH: begin
                if (tx_push) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= ST_IDLE;
            hdr_idx_reg <= 3'h0;
            hdr_last_reg <= 3'h0;
            is_rd_reply_reg <= 1'h0;
            crc_tx_reg <= CRC_INIT;
        end else begin
            state_reg <= state_next;
            if (do_reply) begin
                hdr_idx_reg <= 3'h0;
                hdr_last_reg <= reply_echo ? HDR_LAST_ECHO : HDR_LAST_SHORT;
                is_rd_reply_reg <= reply_read;
                crc_tx_reg <= CRC_INIT;
            end else begin
                if (tx_push && in_head && !head_done) begin
                    hdr_idx_reg <= hdr_idx_reg + 3'h1;
                end
                if (crc_push) begin
                    crc_tx_reg <= crc_tx_next;
                end
            end
        end
    end

    // header bytes are fixed by the time the first one is sent
    always_ff @(posedge clk_sys_in) begin
        if (do_reply) begin
            hdr_reg[0] <= f_addr;
            hdr_reg[3] <= rx_buf[3];
            hdr_reg[4] <= rx_buf[4];
            hdr_reg[5] <= rx_buf[5];
            if (reply_read) begin
                hdr_reg[1] <= f_func;
                hdr_reg[2] <= {f_val[6:0], 1'h0};
            end else if (reply_echo) begin
                hdr_reg[1] <= f_func;
                hdr_reg[2] <= rx_buf[2];
            end else begin
                hdr_reg[1] <= f_func | EXC_FLAG;
                hdr_reg[2] <= exc_code;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // holding register access

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_base_reg <= 17'h00000;
            rd_qty_reg <= 7'h00;
            rd_idx_reg <= 7'h00;
            word_reg <= 16'h0000;
            reg_rd_out <= '0;
            reg_wr_out <= '0;
            crc_err_out <= 1'h0;
        end else begin
            crc_err_out <= frame_done_reg && !crc_ok;
            reg_wr_out.en <= do_write;
            if (do_write) begin
                reg_wr_out.addr <= f_reg_num;
                reg_wr_out.data <= f_val;
            end
            if (reply_read) begin
                rd_base_reg <= f_reg_num;
                rd_qty_reg <= f_val[6:0];
                rd_idx_reg <= 7'h00;
            end
            reg_rd_out.en <= state_reg == ST_RDADDR;
            if (state_reg == ST_RDADDR) begin
                reg_rd_out.addr <= rd_base_reg + {10'h000, rd_idx_reg};
            end
            if (state_reg == ST_RDDATA) begin
                word_reg <= reg_rd_data_in;
            end
            if (tx_push && state_reg == ST_RDLO) begin
                rd_idx_reg <= rd_idx_inc;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!resetn_in);
    a_rd_bcast_drop: assert property (
        frame_done_reg && f_addr == BCAST_ADDR && is_read
        |=> state_reg == ST_IDLE && !reg_rd_out.en
    ) else $error("broadcast read was not dropped");
    a_bcast_write: assert property (
        frame_good && is_write && bcast
        |=> reg_wr_out.en && state_reg == ST_IDLE ##1 !sending [*4]
    ) else $error("broadcast write not silent or not done");
    a_wr_map: assert property (
        do_write |=> reg_wr_out.addr == $past(f_field) + REG_BASE &&
                     reg_wr_out.data == $past(f_val)
    ) else $error("write register mapping wrong");
    a_rd_base: assert property (
        reply_read |=> rd_base_reg == $past(f_field) + REG_BASE
    ) else $error("read start mapping wrong");
    // strobe seen in the wait state, data taken next, high byte after that
    a_rd_addr: assert property (
        $rose(reg_rd_out.en) |-> reg_rd_out.addr ==
            rd_base_reg + {10'h000, rd_idx_reg} ##2 state_reg == ST_RDHI
    ) else $error("read address not ascending");
    a_byte_count: assert property (
        tx_push && in_head && hdr_idx_reg == 3'h2 && is_rd_reply_reg
        |-> tx_byte == {rd_qty_reg, 1'h0} &&
            tx_byte >= 8'h02 && tx_byte <= 8'hFA
    ) else $error("byte count wrong");
    a_rd_count: assert property (
        tx_push && in_crcl && is_rd_reply_reg
        |-> rd_idx_reg == rd_qty_reg && rd_qty_reg != 7'h00
    ) else $error("word count differs from quantity");
    a_exc_func: assert property (
        reply_exc |=> in_head && hdr_reg[1] == ($past(f_func) | EXC_FLAG)
    ) else $error("exception function code wrong");
    a_echo_addr: assert property (
        tx_push && in_head && hdr_idx_reg == 3'h0
        |-> tx_byte == station_number_setting_in && station_ok
    ) else $error("reply address not own station");
    a_crc_drop: assert property (
        frame_done_reg && !crc_ok
        |=> state_reg == ST_IDLE && !reg_wr_out.en && crc_err_out
    ) else $error("bad frame not dropped");
    a_gap_hold: assert property (
        rx_valid_in |=> !frame_done_reg [*8]
    ) else $error("frame closed before idle gap");
endmodule

// *** mbrw_server_tb.sv ***
`timescale 1ns/1ps
module mbrw_server_tb import mbrw_pkg::*; ;
    localparam int GAP = 20;
    logic clk_sys_in, resetn_in, rx_valid, tx_valid, tx_ready, crc_err;
    logic slow, hold;
    logic [7:0] station, rx_byte, tx_byte;
    logic [15:0] reg_rd_data = 16'h0000;
    logic rd_pend = 1'b0;
    mbrw_rd_t reg_rd;
    mbrw_wr_t reg_wr;
    logic [16:0] wr_addr;
    logic [15:0] wr_data;
    int wr_n = 0;
    int err_n = 0;
    int num_errors = 0;
    int tests_run = 0;

    mbrw_server #(.GAP_CYCLES_P(GAP)) mbrw_server_inst (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .station_number_setting_in(station),
        .rx_byte_in(rx_byte), .rx_valid_in(rx_valid),
        .tx_byte_out(tx_byte), .tx_valid_out(tx_valid),
        .tx_ready_in(tx_ready), .reg_rd_out(reg_rd),
        .reg_rd_data_in(reg_rd_data), .reg_wr_out(reg_wr),
        .crc_err_out(crc_err));

    mbrw_client_model #(.GAP_P(GAP)) mbrw_client_model_inst (
        .clk_sys_in(clk_sys_in), .tx_byte_in(tx_byte),
        .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
        .rx_byte_out(rx_byte), .rx_valid_out(rx_valid),
        .slow_in(slow), .hold_in(hold));

    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // holding registers: one cycle read latency, data scrambled otherwise
    function automatic logic [15:0] val(input logic [16:0] a);
        return a[15:0] ^ 16'h5A3C;
    endfunction

    // the word stands in the cycle after the strobe, as the server samples it
    always @(negedge clk_sys_in) begin
        rd_pend <= reg_rd.en === 1'b1;
        if (rd_pend) reg_rd_data <= val(reg_rd.addr);
        else reg_rd_data <= ~reg_rd_data;
    end

    always @(posedge clk_sys_in) begin
        if (reg_wr.en === 1'b1) begin
            wr_n++;
            wr_addr = reg_wr.addr;
            wr_data = reg_wr.data;
        end
        if (crc_err === 1'b1) err_n++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic expect_reply(input logic [7:0] e[$]);
        int k;
        k = 0;
        while (mbrw_client_model_inst.got_q.size() < e.size() && k < 3000) begin
            @(negedge clk_sys_in);
            k++;
        end
        // any byte beyond the expected reply shows up as a size mismatch
        repeat (30) @(negedge clk_sys_in);
        chk(mbrw_client_model_inst.got_q.size(), e.size());
        foreach (e[i]) begin
            chk(mbrw_client_model_inst.got_q[i], e[i]);
        end
        mbrw_client_model_inst.got_q = {};
    endtask

    task automatic add_crc(inout logic [7:0] e[$]);
        logic [15:0] c;
        c = mbrw_client_model_inst.crc16(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_write(input logic [7:0] a, input logic [15:0] r,
        input logic [15:0] v);
        logic [7:0] q[$];
        int n0;
        n0 = wr_n;
        q = {a, FC_WRITE, r[15:8], r[7:0], v[15:8], v[7:0]};
        mbrw_client_model_inst.send(q, 1'b0);
        if (a == 8'h00) q = {};
        else q = mbrw_client_model_inst.sent_q;
        expect_reply(q);
        chk(wr_n - n0, 1);
        chk(wr_addr, 17'(r) + REG_BASE);
        chk(wr_data, v);
        $display("write test to %0h done", a);
    endtask

    task automatic t_read(input logic [7:0] a, input logic [15:0] s,
        input logic [15:0] n, input logic h);
        logic [7:0] q[$];
        logic [15:0] v;
        q = {a, FC_READ, s[15:8], s[7:0], n[15:8], n[7:0]};
        hold <= h;
        mbrw_client_model_inst.send(q, 1'b0);
        repeat (20) @(negedge clk_sys_in);
        hold <= 1'b0;
        q = {a, FC_READ, 8'(2 * n)};
        for (int i = 0; i < n; i++) begin
            v = val(17'(s) + REG_BASE + 17'(i));
            q.push_back(v[15:8]);
            q.push_back(v[7:0]);
        end
        add_crc(q);
        if (a == 8'h00) q = {};
        expect_reply(q);
        $display("read test of %0d words done", n);
    endtask

    task automatic t_exc(input logic [7:0] f, input logic [15:0] n,
        input logic [7:0] code);
        logic [7:0] q[$];
        q = {station, f, 8'h00, 8'h01, n[15:8], n[7:0]};
        mbrw_client_model_inst.send(q, 1'b0);
        q = {station, f | EXC_FLAG, code};
        add_crc(q);
        expect_reply(q);
        $display("exception test %0h done", f);
    endtask

    task automatic t_drop(input logic [7:0] a, input logic bad);
        logic [7:0] q[$];
        int n0;
        int e0;
        n0 = wr_n;
        e0 = err_n;
        q = {a, FC_WRITE, 8'h00, 8'h02, 8'h12, 8'h34};
        mbrw_client_model_inst.send(q, bad);
        q = {};
        expect_reply(q);
        chk(wr_n - n0, 0);
        chk(err_n - e0, 32'(bad));
        $display("drop test done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk_sys_in);
        num_errors++;
        report_and_stop;
    end

    initial begin
        resetn_in = 1'b0;
        station = 8'h05;
        slow = 1'b0;
        hold = 1'b0;
        repeat (16) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        resetn_in = 1'b1;
        t_write(8'h05, 16'h000D, 16'h1770);
        chk({mbrw_client_model_inst.sent_q[6],
            mbrw_client_model_inst.sent_q[7]}, 16'h1799);
        t_write(8'h00, 16'h0001, 16'hBEEF);
        station = 8'hF7;
        t_write(8'hF7, 16'hFFFE, 16'h0000);
        station = 8'h11;
        t_read(8'h11, 16'h03EB, 16'h0003, 1'b1);
        chk({mbrw_client_model_inst.sent_q[6],
            mbrw_client_model_inst.sent_q[7]}, 16'h772B);
        t_read(8'h11, 16'h0000, 16'h0001, 1'b0);
        slow <= 1'b1;
        t_read(8'h11, 16'hFF80, 16'h007D, 1'b1);
        slow <= 1'b0;
        t_read(8'h00, 16'h0010, 16'h0002, 1'b0);
        t_exc(8'h41, 16'h0001, 8'h01);
        t_exc(FC_READ, 16'h007E, 8'h03);
        t_drop(8'h11, 1'b1);
        t_drop(8'h12, 1'b0);
        report_and_stop;
    end
endmodule

// *** mbrw_skid2.sv ***
`timescale 1ns/1ps
module mbrw_skid2 #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // filling side
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    // draining side
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    logic [WIDTH-1:0] spare_reg;
    logic spare_valid_reg;
    wire pop = out_valid_out & out_ready_in;
    wire push = in_valid_in & in_ready_out;

    // ready comes from a flop so the source never sees a combinational loop
    assign in_ready_out = ~spare_valid_reg;

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            out_data_out <= '0;
            out_valid_out <= 1'h0;
            spare_reg <= '0;
            spare_valid_reg <= 1'h0;
        end else if (spare_valid_reg) begin
            if (pop) begin
                out_data_out <= spare_reg;
                spare_valid_reg <= 1'h0;
            end
        end else if (push) begin
            if (!out_valid_out || pop) begin
                out_data_out <= in_data_in;
                out_valid_out <= 1'h1;
            end else begin
                spare_reg <= in_data_in;
                spare_valid_reg <= 1'h1;
            end
        end else if (pop) begin
            out_valid_out <= 1'h0;
        end
    end
endmodule
